// ==== src/arith_logic_exec_unit.sv ====
// Execution datapath: byte and word arithmetic, logic, pointer flow and I/O bit operations
// Overview of operation
// [RULE_01] Add registers, optional carry, one clock
// [RULE_02] Word immediate add, five flags, two clocks
// [RULE_03] Subtract register or immediate, one clock
// [RULE_04] Word immediate subtract, five flags, two clocks
// [RULE_05] Subtract operand and carry, one clock
// [RULE_06] Bitwise ops update Z, N, V only
// [RULE_07] Set bits ORs, clear bits ANDs inverted
// [RULE_08] Test ANDs register with itself, sets flags
// [RULE_09] Pointer jump loads PC from Z, two clocks
// [RULE_10] Pointer call pushes return, three clocks
// [RULE_11] Compare-skip advances PC by two or three
// [RULE_12] Some flags clear by writing one
// [RULE_13] Bit ops rewrite whole register, clearing flags
// [RULE_14] Bit ops only reach addresses 0x00-0x1F
// [RULE_15] Software avoids reserved bits and addresses
// [RULE_16] Flags follow usual zero, sign, carry meaning
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module arith_logic_exec_unit
  import exec_pkg::*;
(
  input wire logic clock_i, // Core clock, 25 MHz
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic [11:0] paddr_i, // APB address
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  input wire logic op_valid_i, // Decoder presents an operation
  input wire exec_op_type op_code_i, // Operation
  input wire logic [7:0] rd_val_i, // Destination register value
  input wire logic [7:0] rr_val_i, // Source register value
  input wire logic [7:0] imm_i, // Immediate constant
  input wire logic [15:0] pair_val_i, // Register pair value
  input wire logic [15:0] z_ptr_i, // Z pointer pair
  input wire logic [15:0] pc_i, // Current program counter
  input wire logic skip_two_word_i, // Next instruction is two words
  input wire logic [5:0] io_addr_i, // I/O address for bit ops
  input wire logic [2:0] io_bit_i, // Bit number for bit ops
  input wire logic [7:0] flag_event_i, // Events setting I/O flags
  output logic ready_o, // Can take an operation
  output logic done_o, // Operation completes
  output logic [7:0] result_o, // Byte result
  output logic result_we_o, // Write byte result to destination
  output logic [15:0] word_o, // Word result
  output logic word_we_o, // Write word result to pair
  output logic [15:0] pc_o, // New program counter
  output logic pc_load_o, // Load program counter
  output logic push_o, // Push return address
  output logic [15:0] push_addr_o, // Return address
  output logic [7:0] sreg_o // Status flags
);
  typedef enum logic {ST_IDLE, ST_WAIT} exec_state_type;

  exec_state_type state_reg, state_next;
  logic [1:0] cnt_reg;
  logic ready_reg, done_reg, result_we_reg, word_we_reg, pc_load_reg, push_reg;
  logic [7:0] result_reg, sreg_reg;
  logic [15:0] word_reg, pc_reg, push_addr_reg;
  logic pend_res_reg, pend_word_reg, pend_pc_reg, pend_push_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;

  io_bank_if bank();

  // Operand selection and decode
  wire logic accept = op_valid_i && ready_reg && (op_code_i != OP_NONE);
  wire logic is_test = (op_code_i == OP_ZERO_SIGN_CHECK);
  wire logic [7:0] operand_b = is_imm_op(op_code_i) ? imm_i : (is_test ? rd_val_i : rr_val_i);
  wire logic use_carry = op_code_i inside {OP_ADD_CARRY, OP_DIFFERENCE_WITH_BORROW,
                                           OP_IMMEDIATE_DIFFERENCE_WITH_BORROW}; // RULE_05
  wire logic equal = (rd_val_i == rr_val_i);
  wire logic [1:0] cycles = op_cycles(op_code_i, equal);

  // Byte adder
  logic [7:0] sum;
  logic sum_carry, sum_half, sum_ovf;
  byte_adder u_adder (
    .a_i(rd_val_i),
    .b_i(operand_b),
    .carry_i(use_carry & sreg_reg[FLAG_C]),
    .sub_i(is_sub_op(op_code_i)),
    .res_o(sum),
    .carry_o(sum_carry),
    .half_o(sum_half),
    .ovf_o(sum_ovf)
  ); // RULE_01 RULE_03

  // Bitwise results
  wire logic [7:0] logic_res =
    (op_code_i inside {OP_OR, OP_MERGE_IMMEDIATE, OP_SET_BITS_IMMEDIATE}) ? (rd_val_i | operand_b) : // RULE_07
    (op_code_i == OP_EXCLUSIVE_MERGE) ? (rd_val_i ^ operand_b) :
    (op_code_i == OP_CLEAR_BITS_IMMEDIATE) ? (rd_val_i & (FULL_MASK ^ imm_i)) : // RULE_07
    (rd_val_i & operand_b); // RULE_06 RULE_08

  // Word add and subtract on the pair
  wire logic word_sub = (op_code_i == OP_WORD_IMMEDIATE_DIFFERENCE);
  wire logic [15:0] word_k = {10'h000, imm_i[5:0]};
  wire logic [16:0] word_wide = word_sub ? ({1'b0, pair_val_i} - {1'b0, word_k})
                                         : ({1'b0, pair_val_i} + {1'b0, word_k}); // RULE_02 RULE_04
  wire logic [15:0] word_res = word_wide[15:0];
  wire logic word_ovf = word_sub ? (pair_val_i[15] & ~word_res[15]) : (~pair_val_i[15] & word_res[15]);
  wire logic word_neg = word_res[15];

  // Flag images per operation class
  wire logic [7:0] sreg_arith = {sreg_reg[7:6], sum_half, sreg_reg[4], sum_ovf, sum[7],
                                 (sum == 8'h00), sum_carry}; // RULE_01 RULE_03 RULE_05 RULE_16
  wire logic [7:0] sreg_logic = {sreg_reg[7:4], 1'b0, logic_res[7], (logic_res == 8'h00),
                                 sreg_reg[0]}; // RULE_06 RULE_08
  wire logic [7:0] sreg_word = {sreg_reg[7:5], word_neg ^ word_ovf, word_ovf, word_neg,
                                (word_res == 16'h0000), word_wide[16]}; // RULE_02 RULE_04 RULE_16
  wire logic is_word = op_code_i inside {OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFFERENCE};
  wire logic [7:0] sreg_op = is_arith_op(op_code_i) ? sreg_arith :
                             is_logic_op(op_code_i) ? sreg_logic :
                             is_word ? sreg_word : sreg_reg; // RULE_09 RULE_10 RULE_11

  // Program flow targets
  wire logic is_flow = op_code_i inside {OP_POINTER_JUMP, OP_POINTER_SUBROUTINE_ENTRY, OP_COMPARE_SKIP_EQUAL};
  wire logic [15:0] skip_step = skip_two_word_i ? PC_SKIP_LONG : PC_SKIP_SHORT;
  wire logic [15:0] pc_target = (op_code_i == OP_COMPARE_SKIP_EQUAL)
                                ? (pc_i + (equal ? skip_step : PC_STEP)) : z_ptr_i; // RULE_09 RULE_11
  wire logic res_we_req = (is_arith_op(op_code_i) || is_logic_op(op_code_i)) && !is_test; // RULE_08

  // I/O bit read-modify-write
  wire logic is_io_bit = op_code_i inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR};
  wire logic io_in_range = (io_addr_i <= IO_BIT_LIMIT); // RULE_14
  wire logic [7:0] bit_mask = BIT0_MASK << io_bit_i;
  assign bank.bit_rd_addr = io_addr_i[4:0];
  assign bank.b_we = accept && is_io_bit && io_in_range; // RULE_14
  assign bank.b_addr = io_addr_i[4:0];
  assign bank.b_data = (op_code_i == OP_IO_BIT_SET) ? (bank.bit_rd_data | bit_mask)
                                                    : (bank.bit_rd_data & ~bit_mask); // RULE_13

  // Register bus decode; reserved space answers with an error
  wire logic apb_access = psel_i && penable_i;
  wire logic apb_done = apb_access && pready_reg;
  wire logic addr_io = (paddr_i <= APB_IO_LAST) && (paddr_i[1:0] == 2'h0);
  wire logic addr_sreg = (paddr_i == APB_SREG_ADDR);
  wire logic addr_err = !(addr_io || addr_sreg); // RULE_15
  wire logic [31:0] rd_sel = addr_io ? {24'h000000, bank.bus_rd_data} :
                             addr_sreg ? {24'h000000, sreg_reg} : 32'h00000000;
  assign bank.bus_rd_addr = paddr_i[6:2];
  assign bank.a_we = apb_done && pwrite_i && addr_io; // RULE_12
  assign bank.a_addr = paddr_i[6:2];
  assign bank.a_data = pwdata_i[7:0];

  // Strobe timing
  wire logic fire_now = accept && (cycles == CYC_ONE);
  wire logic fire_late = (state_reg == ST_WAIT) && (cnt_reg == CYC_ONE);
  assign state_next = (accept && cycles != CYC_ONE) ? ST_WAIT :
                      (state_reg == ST_WAIT && cnt_reg != CYC_ONE) ? ST_WAIT : ST_IDLE;

  io_bank u_bank (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .flag_event_i(flag_event_i),
    .port(bank.bank)
  );

  // Sequencing and cycle count
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 2'h0;
      ready_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= accept ? cycles - CYC_ONE : (fire_late ? 2'h0 : cnt_reg - {1'b0, state_reg == ST_WAIT});
      ready_reg <= (state_next == ST_IDLE); // RULE_02 RULE_09 RULE_10 RULE_11
    end
  end

  // Pending strobes for multi-cycle operations
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      {pend_res_reg, pend_word_reg, pend_pc_reg, pend_push_reg} <= 4'h0;
    else if (accept)
      {pend_res_reg, pend_word_reg, pend_pc_reg, pend_push_reg} <=
        {res_we_req, is_word, is_flow, op_code_i == OP_POINTER_SUBROUTINE_ENTRY};
  end

  // Result strobes
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      {done_reg, result_we_reg, word_we_reg, pc_load_reg, push_reg} <= 5'h00;
    else
    begin
      done_reg <= fire_now || fire_late;
      result_we_reg <= (fire_now && res_we_req) || (fire_late && pend_res_reg);
      word_we_reg <= fire_late && pend_word_reg;
      pc_load_reg <= (fire_now && is_flow) || (fire_late && pend_pc_reg); // RULE_11
      push_reg <= fire_late && pend_push_reg; // RULE_10
    end
  end

  // Result data and status flags; operations win over bus writes
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      {result_reg, word_reg, pc_reg, push_addr_reg} <= 56'h0;
      sreg_reg <= SREG_RESET;
    end
    else if (accept)
    begin
      result_reg <= is_arith_op(op_code_i) ? sum : logic_res;
      word_reg <= word_res;
      pc_reg <= pc_target;
      push_addr_reg <= pc_i + PC_STEP; // RULE_10
      sreg_reg <= sreg_op;
    end
    else if (apb_done && pwrite_i && addr_sreg)
      sreg_reg <= pwdata_i[7:0];
  end

  // Bus answer after one wait state
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      {pready_reg, pslverr_reg, prdata_reg} <= 34'h0;
    else
    begin
      pready_reg <= apb_access && !pready_reg;
      pslverr_reg <= apb_access && !pready_reg && addr_err;
      prdata_reg <= (apb_access && !pready_reg && !pwrite_i) ? rd_sel : 32'h00000000;
    end
  end

  // Outputs
  assign {ready_o, done_o, result_o, result_we_o} = {ready_reg, done_reg, result_reg, result_we_reg};
  assign {word_o, word_we_o, pc_o, pc_load_o} = {word_reg, word_we_reg, pc_reg, pc_load_reg};
  assign {push_o, push_addr_o, sreg_o} = {push_reg, push_addr_reg, sreg_reg};
  assign {prdata_o, pready_o, pslverr_o} = {prdata_reg, pready_reg, pslverr_reg};

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_add_one_clock: // RULE_01
    assert property (accept && op_code_i inside {OP_ADD, OP_ADD_CARRY}
                     |=> done_o && result_we_o && sreg_o[FLAG_Z] == (result_o == 8'h00))
    else $error("add did not finish in one clock");
  a_word_sum_two: // RULE_02
    assert property (accept && op_code_i == OP_WORD_IMMEDIATE_SUM
                     |=> !done_o ##1 (done_o && word_we_o
                     && word_o == 16'($past(pair_val_i, 2) + {10'h000, $past(imm_i[5:0], 2)})))
    else $error("word add timing or value wrong");
  a_diff_borrow: // RULE_03
    assert property (accept && op_code_i == OP_DIFFERENCE_IMMEDIATE
                     |=> done_o && sreg_o[FLAG_C] == ($past(rd_val_i) < $past(imm_i)))
    else $error("subtract borrow wrong");
  a_word_diff_sign: // RULE_04
    assert property (accept && op_code_i == OP_WORD_IMMEDIATE_DIFFERENCE
                     |=> !word_we_o ##1 (word_we_o && sreg_o[FLAG_S] == (sreg_o[FLAG_N] ^ sreg_o[FLAG_V])))
    else $error("word subtract sign or timing wrong");
  a_borrow_chain: // RULE_05
    assert property (accept && op_code_i == OP_DIFFERENCE_WITH_BORROW
                     |=> result_o == 8'($past(rd_val_i) - $past(rr_val_i) - {7'h00, $past(sreg_o[FLAG_C])}))
    else $error("subtract with borrow wrong");
  a_logic_flags: // RULE_06
    assert property (accept && is_logic_op(op_code_i)
                     |=> !sreg_o[FLAG_V] && sreg_o[FLAG_C] == $past(sreg_o[FLAG_C])
                     && sreg_o[FLAG_H] == $past(sreg_o[FLAG_H]))
    else $error("bitwise op touched wrong flags");
  a_clear_bits: // RULE_07
    assert property (accept && op_code_i == OP_CLEAR_BITS_IMMEDIATE
                     |=> result_we_o && result_o == ($past(rd_val_i) & ~$past(imm_i)))
    else $error("clear bits result wrong");
  a_check_keeps: // RULE_08
    assert property (accept && is_test |=> done_o && !result_we_o && sreg_o[FLAG_N] == $past(rd_val_i[7]))
    else $error("test op wrote or flagged wrong");
  a_jump_two: // RULE_09
    assert property (accept && op_code_i == OP_POINTER_JUMP
                     |=> !pc_load_o ##1 (pc_load_o && pc_o == $past(z_ptr_i, 2) && sreg_o == $past(sreg_o, 2)))
    else $error("pointer jump wrong");
  a_call_three: // RULE_10
    assert property (accept && op_code_i == OP_POINTER_SUBROUTINE_ENTRY
                     |=> (!done_o)[*2] ##1 (push_o && pc_load_o && push_addr_o == 16'($past(pc_i, 3) + 16'h0001)))
    else $error("pointer call wrong");
  a_skip_equal: // RULE_11
    assert property (accept && op_code_i == OP_COMPARE_SKIP_EQUAL && equal
                     |=> !done_o ##1 (done_o && pc_load_o && pc_o == 16'($past(pc_i, 2) + $past(skip_step, 2))))
    else $error("compare skip wrong");
  a_io_range: // RULE_14
    assert property (accept && is_io_bit && io_addr_i > IO_BIT_LIMIT |-> !bank.b_we)
    else $error("bit op outside low I/O range");
endmodule : arith_logic_exec_unit

// ==== src/byte_adder.sv ====
// Eight-bit add/subtract with carry, half-carry and overflow
`timescale 1ns/10ps
module byte_adder
  import exec_pkg::*;
(
  input wire logic [7:0] a_i, // Destination operand
  input wire logic [7:0] b_i, // Source operand
  input wire logic carry_i, // Incoming carry or borrow
  input wire logic sub_i, // High to subtract
  output logic [7:0] res_o, // Result byte
  output logic carry_o, // Unsigned carry or borrow
  output logic half_o, // Carry or borrow out of bit 3
  output logic ovf_o // Signed overflow
);
  logic [8:0] wide;
  logic [4:0] nib;
  logic b_eff;

  // Full and low-nibble sums
  assign wide = sub_i ? ({1'b0, a_i} - {1'b0, b_i} - {8'h00, carry_i})
                      : ({1'b0, a_i} + {1'b0, b_i} + {8'h00, carry_i});
  assign nib = sub_i ? ({1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, carry_i})
                     : ({1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, carry_i});

  // Flag outputs
  assign res_o = wide[7:0];
  assign carry_o = wide[8]; // RULE_16
  assign half_o = nib[4];
  assign b_eff = b_i[7] ^ sub_i;
  assign ovf_o = (a_i[7] & b_eff & ~wide[7]) | (~a_i[7] & ~b_eff & wide[7]);
endmodule : byte_adder

// ==== src/exec_pkg.sv ====
// Shared constants, operation codes and decode functions for the execution datapath
package exec_pkg;

  // Data widths
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;

  // Status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  // Reset values and masks
  localparam logic [7:0] SREG_RESET = 8'h00;
  localparam logic [7:0] IO_RESET = 8'h00;
  localparam logic [7:0] FULL_MASK = 8'hFF;
  localparam logic [7:0] BIT0_MASK = 8'h01;

  // Cycle counts per operation class
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // Program counter steps
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] PC_SKIP_SHORT = 16'h0002;
  localparam logic [15:0] PC_SKIP_LONG = 16'h0003;

  // I/O space
  localparam int IO_BANK_DEPTH = 32;
  localparam logic [5:0] IO_BIT_LIMIT = 6'h1F;
  localparam logic [4:0] IO_FLAG_IDX = 5'h08;

  // Register bus map (byte addresses)
  localparam int APB_ADDR_W = 12;
  localparam logic [11:0] APB_IO_LAST = 12'h07C;
  localparam logic [11:0] APB_SREG_ADDR = 12'h080;

  // Operations presented by the decoder
  typedef enum logic [4:0] {
    OP_NONE,
    OP_ADD,
    OP_ADD_CARRY,
    OP_DIFFERENCE,
    OP_DIFFERENCE_IMMEDIATE,
    OP_DIFFERENCE_WITH_BORROW,
    OP_IMMEDIATE_DIFFERENCE_WITH_BORROW,
    OP_AND,
    OP_MASK_IMMEDIATE,
    OP_OR,
    OP_MERGE_IMMEDIATE,
    OP_EXCLUSIVE_MERGE,
    OP_SET_BITS_IMMEDIATE,
    OP_CLEAR_BITS_IMMEDIATE,
    OP_ZERO_SIGN_CHECK,
    OP_WORD_IMMEDIATE_SUM,
    OP_WORD_IMMEDIATE_DIFFERENCE,
    OP_POINTER_JUMP,
    OP_POINTER_SUBROUTINE_ENTRY,
    OP_COMPARE_SKIP_EQUAL,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR
  } exec_op_type;

  // Byte arithmetic group
  function automatic logic is_arith_op(exec_op_type op);
    return op inside {OP_ADD, OP_ADD_CARRY, OP_DIFFERENCE, OP_DIFFERENCE_IMMEDIATE,
                      OP_DIFFERENCE_WITH_BORROW, OP_IMMEDIATE_DIFFERENCE_WITH_BORROW};
  endfunction : is_arith_op

  // Subtracting members of the byte group
  function automatic logic is_sub_op(exec_op_type op);
    return op inside {OP_DIFFERENCE, OP_DIFFERENCE_IMMEDIATE,
                      OP_DIFFERENCE_WITH_BORROW, OP_IMMEDIATE_DIFFERENCE_WITH_BORROW};
  endfunction : is_sub_op

  // Bitwise group
  function automatic logic is_logic_op(exec_op_type op);
    return op inside {OP_AND, OP_MASK_IMMEDIATE, OP_OR, OP_MERGE_IMMEDIATE, OP_EXCLUSIVE_MERGE,
                      OP_SET_BITS_IMMEDIATE, OP_CLEAR_BITS_IMMEDIATE, OP_ZERO_SIGN_CHECK};
  endfunction : is_logic_op

  // Operations taking the immediate as second operand
  function automatic logic is_imm_op(exec_op_type op);
    return op inside {OP_DIFFERENCE_IMMEDIATE, OP_IMMEDIATE_DIFFERENCE_WITH_BORROW,
                      OP_MASK_IMMEDIATE, OP_MERGE_IMMEDIATE, OP_SET_BITS_IMMEDIATE};
  endfunction : is_imm_op

  // Clock count of an operation
  function automatic logic [1:0] op_cycles(exec_op_type op, logic equal);
    case (op)
      OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFFERENCE, OP_POINTER_JUMP: return CYC_TWO;
      OP_IO_BIT_SET, OP_IO_BIT_CLEAR: return CYC_TWO;
      OP_POINTER_SUBROUTINE_ENTRY: return CYC_THREE;
      OP_COMPARE_SKIP_EQUAL: return equal ? CYC_TWO : CYC_ONE;
      default: return CYC_ONE;
    endcase
  endfunction : op_cycles

endpackage : exec_pkg

// ==== src/io_bank.sv ====
// I/O register bank with write-one-to-clear event flags
`timescale 1ns/10ps
module io_bank
  import exec_pkg::*;
#(
  parameter int DEPTH = IO_BANK_DEPTH
)(
  input wire logic clock_i, // Core clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic [7:0] flag_event_i, // Hardware events into flag register
  io_bank_if.bank port // Datapath ports
);
  logic [7:0] mem_reg [DEPTH];

  // Depth check
  if (DEPTH < 1 || DEPTH > IO_BANK_DEPTH) begin : g_bad_depth
    $error("io_bank depth out of range");
  end

  // One storage entry per address
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    wire logic hit_a = port.a_we && (port.a_addr == 5'(i));
    wire logic hit_b = port.b_we && (port.b_addr == 5'(i));
    wire logic [7:0] plain_next = hit_b ? port.b_data : (hit_a ? port.a_data : mem_reg[i]);
    wire logic [7:0] clr_mask = (hit_a ? port.a_data : 8'h00) | (hit_b ? port.b_data : 8'h00);
    // Ones clear flags, a new event wins over the clear
    wire logic [7:0] flag_next = (mem_reg[i] & ~clr_mask) | flag_event_i; // RULE_12
    always_ff @(posedge clock_i)
    begin
      if (!rst_n_i)
        mem_reg[i] <= IO_RESET;
      else
        mem_reg[i] <= (5'(i) == IO_FLAG_IDX) ? flag_next : plain_next;
    end
  end

  // Read ports
  assign port.bus_rd_data = (int'(port.bus_rd_addr) < DEPTH) ? mem_reg[port.bus_rd_addr] : 8'h00;
  assign port.bit_rd_data = (int'(port.bit_rd_addr) < DEPTH) ? mem_reg[port.bit_rd_addr] : 8'h00;
endmodule : io_bank

// ==== src/io_bank_if.sv ====
// Write and read ports between the datapath and the I/O register bank
`timescale 1ns/10ps
interface io_bank_if;
  logic a_we;
  logic [4:0] a_addr;
  logic [7:0] a_data;
  logic b_we;
  logic [4:0] b_addr;
  logic [7:0] b_data;
  logic [4:0] bus_rd_addr;
  logic [7:0] bus_rd_data;
  logic [4:0] bit_rd_addr;
  logic [7:0] bit_rd_data;

  modport requester(output a_we, a_addr, a_data, b_we, b_addr, b_data, bus_rd_addr, bit_rd_addr,
                    input bus_rd_data, bit_rd_data);
  modport bank(input a_we, a_addr, a_data, b_we, b_addr, b_data, bus_rd_addr, bit_rd_addr,
               output bus_rd_data, bit_rd_data);
endinterface : io_bank_if

// ==== testbench/op_feeder.sv ====
// Decoder and register file stand-in that presents operations to the datapath
`timescale 1ns/10ps
module op_feeder
  import exec_pkg::*;
(
  input wire logic clock_i, // Core clock
  input wire logic ready_i, // Datapath idle
  input wire logic done_i, // Completion strobe
  output logic op_valid_o, // Operation presented
  output exec_op_type op_o, // Operation
  output logic [7:0] rd_o, // Destination value
  output logic [7:0] rr_o, // Source value
  output logic [7:0] imm_o, // Immediate
  output logic [15:0] pair_o, // Register pair
  output logic [15:0] z_o, // Pointer pair
  output logic [15:0] pc_o, // Program counter
  output logic two_o, // Two-word successor
  output logic [5:0] io_a_o, // I/O address
  output logic [2:0] io_b_o // I/O bit
);
  // Quiet bus at time zero
  initial
  begin
    op_o = OP_NONE;
    {op_valid_o, rd_o, rr_o, imm_o, pair_o, z_o, pc_o, two_o, io_a_o, io_b_o} = '0;
  end

  // Hold the operation until taken, then count clocks up to done
  task automatic run(input exec_op_type op, input logic [65:0] v, output int n);
    int k;
    @(posedge clock_i);
    op_valid_o <= 1'b1;
    op_o <= op;
    {rd_o, rr_o, imm_o, pair_o, z_o, two_o, io_a_o, io_b_o} <= v;
    pc_o <= ~v[25:10];
    #1;
    for (k = 0; ready_i !== 1'b1; k++)
    begin
      if (k > 20) test_arith_logic_exec_unit.hang();
      @(posedge clock_i);
      #1;
    end
    @(posedge clock_i);
    op_valid_o <= 1'b0;
    #1;
    for (n = 1; done_i !== 1'b1; n++)
    begin
      if (n > 20) test_arith_logic_exec_unit.hang();
      @(posedge clock_i);
      #1;
    end
  endtask : run
endmodule : op_feeder

// ==== testbench/test_arith_logic_exec_unit.sv ====
// Self-checking bench for the execution datapath
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; $display("BAD %0t %0h %0h", $time, g, e); end end
module test_arith_logic_exec_unit
  import exec_pkg::*;
;
  int miscompares = 0, num_checks = 0, seed = 32'h0C18, n, i;
  logic clock_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, e;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, r;
  logic [7:0] flag_event_i = 8'h00, sr = 8'h00, a, b, rd_val_i, rr_val_i, imm_i, result_o, sreg_o;
  logic [15:0] pair_val_i, z_ptr_i, pc_i, word_o, pc_o, push_addr_o, w, t;
  logic [16:0] x;
  logic [5:0] io_addr_i;
  logic [2:0] io_bit_i;
  logic pready_o, pslverr_o, op_valid_i, skip_two_word_i, ready_o, done_o, result_we_o, word_we_o, pc_load_o, push_o;
  exec_op_type op, op_code_i;

  always #20 clock_i = ~clock_i;

  arith_logic_exec_unit i_arith_logic_exec_unit (.clock_i, .rst_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .op_valid_i, .op_code_i, .rd_val_i, .rr_val_i, .imm_i,
    .pair_val_i, .z_ptr_i, .pc_i, .skip_two_word_i, .io_addr_i, .io_bit_i, .flag_event_i, .ready_o, .done_o,
    .result_o, .result_we_o, .word_o, .word_we_o, .pc_o, .pc_load_o, .push_o, .push_addr_o, .sreg_o);
  op_feeder i_op_feeder (.clock_i, .ready_i(ready_o), .done_i(done_o), .op_valid_o(op_valid_i), .op_o(op_code_i),
    .rd_o(rd_val_i), .rr_o(rr_val_i), .imm_o(imm_i), .pair_o(pair_val_i), .z_o(z_ptr_i), .pc_o(pc_i),
    .two_o(skip_two_word_i), .io_a_o(io_addr_i), .io_b_o(io_bit_i));

  // Expected byte result; updates the expected status
  function automatic logic [7:0] calc(exec_op_type o, logic [7:0] p, logic [7:0] q);
    logic [8:0] s;
    logic ci, h, lg;
    ci = sr[0] & (o inside {OP_ADD_CARRY, OP_DIFFERENCE_WITH_BORROW, OP_IMMEDIATE_DIFFERENCE_WITH_BORROW});
    h = 1'b0;
    lg = 1'b1;
    case (o)
      OP_ADD, OP_ADD_CARRY: begin s = p + q + ci; h = p[3:0] + q[3:0] + ci > 5'd15; lg = 1'b0; end
      OP_AND, OP_MASK_IMMEDIATE: s = p & q;
      OP_OR, OP_MERGE_IMMEDIATE, OP_SET_BITS_IMMEDIATE: s = p | q;
      OP_EXCLUSIVE_MERGE: s = p ^ q;
      OP_CLEAR_BITS_IMMEDIATE: s = p & (8'hFF ^ q);
      OP_ZERO_SIGN_CHECK: s = p & p;
      default: begin s = p - q - ci; h = p[3:0] < q[3:0] + ci + 5'd0; lg = 1'b0; end
    endcase
    sr[1] = s[7:0] == 8'h00;
    sr[2] = s[7];
    sr[3] = !lg && (o inside {OP_ADD, OP_ADD_CARRY} ? p[7] == q[7] : p[7] != q[7]) && s[7] != p[7];
    if (!lg) {sr[5], sr[0]} = {h, s[8]};
    return s[7:0];
  endfunction : calc

  // One register bus transfer
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [7:0] d, output logic [31:0] q,
                     output logic er);
    int k;
    @(posedge clock_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, wr, ad, 24'h0, d};
    @(posedge clock_i);
    penable_i <= 1'b1;
    #1;
    for (k = 0; pready_o !== 1'b1; k++)
    begin
      if (k > 20) hang();
      @(posedge clock_i);
      #1;
    end
    @(posedge clock_i);
    {q, er} = {prdata_o, pslverr_o};
    {psel_i, penable_i} <= 2'b00;
  endtask : apb

  task automatic hang();
    miscompares++;
    results();
  endtask : hang

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // Byte arithmetic and logic, corner operands first
    for (i = 0; i < 84; i++)
    begin
      op = exec_op_type'(i % 14 + 1);
      {a, b} = (i < 14) ? 16'h8001 : 16'($random(seed));
      i_op_feeder.run(op, {a, b, b, 42'h0}, n);
      r[7:0] = calc(op, a, b);
      `CHK(n, 1)
      `CHK(result_we_o, op != OP_ZERO_SIGN_CHECK)
      if (op != OP_ZERO_SIGN_CHECK) `CHK(result_o, r[7:0])
      `CHK(sreg_o, sr)
    end
    $display("byte test done");
    // Word add and subtract with wrap corners
    for (i = 0; i < 8; i++)
    begin
      w = (i < 2) ? {16{~i[0]}} : 16'($random(seed));
      b = 8'($random(seed)) | 8'h01;
      x = i[0] ? w - b[5:0] : w + b[5:0];
      {sr[2], sr[1], sr[0]} = {x[15], x[15:0] == 16'h0, x[16]};
      sr[3] = i[0] ? w[15] & ~x[15] : ~w[15] & x[15];
      sr[4] = sr[2] ^ sr[3];
      i_op_feeder.run(i[0] ? OP_WORD_IMMEDIATE_DIFFERENCE : OP_WORD_IMMEDIATE_SUM, {16'h0, b, w, 26'h0}, n);
      `CHK(n, 2)
      `CHK({word_we_o, word_o}, {1'b1, x[15:0]})
      `CHK(sreg_o, sr)
    end
    $display("word test done");
    // Pointer jump, pointer call, compare-skip unequal, short and long
    for (i = 0; i < 5; i++)
    begin
      {w, a} = 24'($random(seed));
      op = (i == 0) ? OP_POINTER_JUMP : (i == 1) ? OP_POINTER_SUBROUTINE_ENTRY : OP_COMPARE_SKIP_EQUAL;
      i_op_feeder.run(op, {a, a ^ {7'h0, i == 2}, 24'h0, w, i == 4, 9'h0}, n);
      t = 16'(~w + i - 1);
      `CHK(n, i == 1 ? 3 : (i == 2 ? 1 : 2))
      `CHK({pc_load_o, pc_o}, {1'b1, i < 2 ? w : t})
      `CHK(push_o, i == 1)
      if (i == 1) `CHK(push_addr_o, ~w + 16'h1)
      `CHK(sreg_o, sr)
    end
    apb(0, 12'h080, 8'h00, r, e);
    `CHK({e, r}, {25'h0, sr})
    apb(1, 12'h080, 8'h5A, r, e);
    apb(0, 12'h080, 8'h00, r, e);
    `CHK({e, r}, 33'h5A)
    $display("flow test done");
    // Event flags, write-one clear, bit operations and address range
    @(posedge clock_i);
    flag_event_i <= 8'h0C;
    @(posedge clock_i);
    flag_event_i <= 8'h00;
    apb(0, 12'h020, 8'h00, r, e);
    `CHK(r, 32'h0C)
    apb(1, 12'h020, 8'h04, r, e);
    apb(0, 12'h020, 8'h00, r, e);
    `CHK(r, 32'h08)
    i_op_feeder.run(OP_IO_BIT_SET, {57'h0, 6'h08, 3'h0}, n);
    apb(0, 12'h020, 8'h00, r, e);
    `CHK(r, 32'h00)
    apb(1, 12'h040, 8'h55, r, e);
    i_op_feeder.run(OP_IO_BIT_CLEAR, {57'h0, 6'h10, 3'h0}, n);
    i_op_feeder.run(OP_IO_BIT_SET, {57'h0, 6'h30, 3'h1}, n);
    `CHK(n, 2)
    apb(0, 12'h040, 8'h00, r, e);
    `CHK(r, 32'h54)
    apb(0, 12'h084, 8'h00, r, e);
    `CHK({e, r}, 33'h100000000)
    $display("io test done");
    results();
  end
endmodule : test_arith_logic_exec_unit
